//--- design/gated_count_snapshot_logger.sv
// Eight-channel counter and timer with gate- or pacer-paced snapshot memory
`timescale 1ns/10ps
module gated_count_snapshot_logger (
    // Clock and reset
    input  wire logic                                        sys_clk,
    input  wire logic                                        rstn,
    // Pins
    input  wire logic [gated_count_snapshot_pkg::CH_N-1:0]   countPin,
    input  wire logic                                        startPin,
    input  wire logic                                        stopPin,
    input  wire logic                                        gatePin,
    input  wire logic                                        gateNegative,
    output logic                                             runOut,
    // Command port
    input  wire logic                                        cmdValid,
    input  wire gated_count_snapshot_pkg::cmd_type           cmdCode,
    input  wire logic [gated_count_snapshot_pkg::ARG_W-1:0]  cmdArg,
    // Reply port
    output logic                                             replyValid,
    output gated_count_snapshot_pkg::reply_type              replyKind,
    output logic [gated_count_snapshot_pkg::ARG_W-1:0]       replyData
);
    localparam int N  = gated_count_snapshot_pkg::CH_N;
    localparam int CW = gated_count_snapshot_pkg::CNT_W;
    localparam int TW = gated_count_snapshot_pkg::TIM_W;
    localparam int AW = gated_count_snapshot_pkg::ARG_W;
    localparam int PW = gated_count_snapshot_pkg::ADDR_W;
    localparam int PN = gated_count_snapshot_pkg::PIN_N;

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [PN-1:0] syncA_reg;
    logic [PN-1:0] syncB_reg;
    logic [PN-1:0] syncC_reg;
    logic [PN-1:0] pinLvl_reg;
    logic [PN-1:0] pinPrev_reg;
    logic [PN-1:0] pinAgree;
    logic [PN-1:0] pinLvl_next;
    logic [PN-1:0] pinRaw;
    logic [PN-1:0] pinRise;
    logic          gateLvl;
    logic          gateFall;

    // Inverted polarity turns a low gate into the asserted level
    assign pinRaw = {gatePin ^ gateNegative, stopPin, startPin, countPin};
    assign pinAgree    = ~(syncB_reg ^ syncC_reg);
    assign pinLvl_next = (pinAgree & syncC_reg) | (~pinAgree & pinLvl_reg);
    assign pinRise     = pinLvl_reg & ~pinPrev_reg;
    assign gateLvl     = pinLvl_reg[gated_count_snapshot_pkg::PIN_GATE];
    assign gateFall    = ~gateLvl & pinPrev_reg[gated_count_snapshot_pkg::PIN_GATE];

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            syncA_reg   <= '0;
            syncB_reg   <= '0;
            syncC_reg   <= '0;
            pinLvl_reg  <= '0;
            pinPrev_reg <= '0;
        end else begin
            syncA_reg   <= pinRaw;
            syncB_reg   <= syncA_reg;
            syncC_reg   <= syncB_reg;
            pinLvl_reg  <= pinLvl_next;
            pinPrev_reg <= pinLvl_reg;
        end
    end

    // ==========================================================
    // Microsecond tick and pacer timing
    // ==========================================================
    gated_count_snapshot_pkg::acq_type acq_reg;
    gated_count_snapshot_pkg::acq_type acq_next;
    logic [4:0]    pre_reg;
    logic          usTick;
    logic [AW-1:0] pacerCnt_reg;
    logic [2:0]    offCyc_reg;
    logic [AW-1:0] onTime_reg;
    logic [AW-1:0] offTime_reg;
    logic          onDone;
    logic          offDone;
    logic          phaseNew;

    assign usTick  = (pre_reg == gated_count_snapshot_pkg::US_CYC - 5'h01);
    assign onDone  = usTick && (pacerCnt_reg + 41'h1 >= onTime_reg);
    // A zero off time still leaves a short gap between on periods
    assign offDone = (offTime_reg == '0)
                   ? (offCyc_reg == gated_count_snapshot_pkg::OFF_MIN_CYC - 3'h1)
                   : (usTick && (pacerCnt_reg + 41'h1 >= offTime_reg));
    assign phaseNew = (acq_next != acq_reg);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pre_reg      <= '0;
            pacerCnt_reg <= '0;
            offCyc_reg   <= '0;
        end else begin
            pre_reg      <= usTick ? 5'h00 : pre_reg + 5'h01;
            pacerCnt_reg <= phaseNew ? '0 : pacerCnt_reg + {40'h0, usTick};
            offCyc_reg   <= phaseNew ? '0 : offCyc_reg + 3'h1;
        end
    end

    // ==========================================================
    // Acquisition control
    // ==========================================================
    logic          running_reg;
    logic          countOn;
    logic          snap;
    logic          atEnd;
    logic [PW-1:0] ptr_reg;
    logic [PW-1:0] end_reg;
    logic          isCmd;
    logic          doStop;
    logic          doStart;

    assign isCmd   = cmdValid;
    assign doStop  = (isCmd && cmdCode == gated_count_snapshot_pkg::COUNT_STOP_CMD)
                   || pinRise[gated_count_snapshot_pkg::PIN_STOP];
    assign doStart = (isCmd && cmdCode == gated_count_snapshot_pkg::COUNT_BEGIN_CMD)
                   || pinRise[gated_count_snapshot_pkg::PIN_START];
    assign atEnd   = (ptr_reg == end_reg);

    // Snapshot moments per pacing mode
    assign snap = ((acq_reg == gated_count_snapshot_pkg::ACQ_LEVEL) && gateFall)
               || ((acq_reg == gated_count_snapshot_pkg::ACQ_EDGE_RUN) && gateFall)
               || ((acq_reg == gated_count_snapshot_pkg::ACQ_CLK_ON) && onDone);

    always_comb begin
        acq_next = acq_reg;
        case (acq_reg)
            gated_count_snapshot_pkg::ACQ_IDLE: begin
                acq_next = gated_count_snapshot_pkg::ACQ_IDLE;
            end
            gated_count_snapshot_pkg::ACQ_EDGE_ARM: begin
                if (gateFall) begin
                    acq_next = gated_count_snapshot_pkg::ACQ_EDGE_RUN;
                end
            end
            gated_count_snapshot_pkg::ACQ_CLK_ON: begin
                if (onDone) begin
                    acq_next = gated_count_snapshot_pkg::ACQ_CLK_OFF;
                end
            end
            gated_count_snapshot_pkg::ACQ_CLK_OFF: begin
                if (offDone) begin
                    acq_next = gated_count_snapshot_pkg::ACQ_CLK_ON;
                end
            end
            default: begin
                acq_next = acq_reg;
            end
        endcase
        if (snap && atEnd) begin
            acq_next = gated_count_snapshot_pkg::ACQ_IDLE;
        end
        if (isCmd) begin
            case (cmdCode)
                gated_count_snapshot_pkg::LEVEL_GATE_LOG_BEGIN:
                    acq_next = gated_count_snapshot_pkg::ACQ_LEVEL;
                gated_count_snapshot_pkg::EDGE_GATE_LOG_BEGIN:
                    acq_next = gated_count_snapshot_pkg::ACQ_EDGE_ARM;
                gated_count_snapshot_pkg::PACER_LOG_BEGIN:
                    acq_next = gated_count_snapshot_pkg::ACQ_CLK_ON;
                default: begin
                end
            endcase
        end
        if (doStop) begin
            acq_next = gated_count_snapshot_pkg::ACQ_IDLE;
        end
    end

    // Counting gate per mode; the gate pin still applies in pacer mode
    always_comb begin
        case (acq_reg)
            gated_count_snapshot_pkg::ACQ_IDLE:     countOn = running_reg && gateLvl;
            gated_count_snapshot_pkg::ACQ_LEVEL:    countOn = gateLvl;
            gated_count_snapshot_pkg::ACQ_EDGE_RUN: countOn = 1'b1;
            gated_count_snapshot_pkg::ACQ_CLK_ON:   countOn = gateLvl;
            default:                                countOn = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            acq_reg     <= gated_count_snapshot_pkg::ACQ_IDLE;
            running_reg <= 1'b0;
        end else begin
            acq_reg     <= acq_next;
            running_reg <= (acq_next != gated_count_snapshot_pkg::ACQ_IDLE)
                        || (!doStop && (doStart || (running_reg && !(snap && atEnd))));
        end
    end

    assign runOut = countOn;

    // ==========================================================
    // Counters, timer and overflow flags
    // ==========================================================
    logic [N-1:0][CW-1:0] cnt_reg;
    logic [N-1:0][CW-1:0] cnt_next;
    logic [TW-1:0]        tim_reg;
    logic [N-1:0]         ovf_reg;
    logic [N-1:0]         ovfSet;
    logic                 timOvf_reg;
    logic                 timWrap;
    logic                 ovfClr;

    assign timWrap = countOn && usTick && (tim_reg == '1);
    assign ovfClr  = isCmd && (cmdCode == gated_count_snapshot_pkg::COUNT_BEGIN_CMD);

    always_comb begin
        for (int i = 0; i < N; i++) begin
            ovfSet[i]   = countOn && pinRise[i] && (cnt_reg[i] == '1);
            cnt_next[i] = snap ? '0 : cnt_reg[i] + {31'h0, countOn && pinRise[i]};
        end
    end

    // Overflow set wins over the clear in the same cycle
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg    <= '0;
            tim_reg    <= '0;
            ovf_reg    <= '0;
            timOvf_reg <= 1'b0;
        end else begin
            cnt_reg    <= cnt_next;
            tim_reg    <= snap ? '0 : tim_reg + {39'h0, countOn && usTick};
            ovf_reg    <= (ovf_reg & ~{N{ovfClr}}) | ovfSet;
            timOvf_reg <= (timOvf_reg & ~ovfClr) | timWrap;
        end
    end

    // ==========================================================
    // Snapshot memory
    // ==========================================================
    logic [N-1:0][CW-1:0] recCnt [0:9999];
    logic [TW-1:0]        recTim [0:9999];
    logic                 recValid_reg [0:9999];
    logic                 memClr;
    logic [PW-1:0]        rdAddr;
    logic [3:0]           rdSel;
    logic [AW-1:0]        rdWord;

    assign memClr = isCmd && (cmdCode == gated_count_snapshot_pkg::POINTER_AND_MEMORY_CLEAR);
    assign rdSel  = cmdArg[3:0];
    assign rdAddr = cmdArg[17:4];
    // Erased records read as zero through their valid bit
    assign rdWord = (rdAddr > gated_count_snapshot_pkg::REC_LAST || !recValid_reg[rdAddr])
                  ? '0
                  : (rdSel == gated_count_snapshot_pkg::TIMER_SEL)
                  ? {1'b0, recTim[rdAddr]}
                  : (rdSel < gated_count_snapshot_pkg::TIMER_SEL)
                  ? {9'h0, recCnt[rdAddr][rdSel[2:0]]} : '0;

    always_ff @(posedge sys_clk) begin
        if (snap) begin
            recCnt[ptr_reg] <= cnt_reg;
            recTim[ptr_reg] <= tim_reg;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            for (int a = 0; a < 10000; a++) begin
                recValid_reg[a] <= 1'b0;
            end
        end else if (memClr) begin
            for (int a = 0; a < 10000; a++) begin
                recValid_reg[a] <= 1'b0;
            end
        end else if (snap) begin
            recValid_reg[ptr_reg] <= 1'b1;
        end
    end

    // ==========================================================
    // Command decode and reply
    // ==========================================================
    logic          ackMode_reg;
    logic          ackNext;
    logic          argAddrOk;
    logic          argOnOk;
    logic          argOffOk;
    logic          accept;
    logic          isQuery;
    logic [AW-1:0] queryData;
    logic [7:0]    flag2;
    logic [7:0]    flag3;

    assign argAddrOk = (cmdArg <= {27'h0, gated_count_snapshot_pkg::REC_LAST});
    assign argOnOk   = (cmdArg >= gated_count_snapshot_pkg::PACER_RST)
                    && (cmdArg <= gated_count_snapshot_pkg::PACER_MAX);
    assign argOffOk  = (cmdArg <= gated_count_snapshot_pkg::PACER_MAX);
    assign accept    = !((cmdCode == gated_count_snapshot_pkg::SET_RECORD_POINTER
                        || cmdCode == gated_count_snapshot_pkg::SET_END_POINTER) && !argAddrOk)
                    && !(cmdCode == gated_count_snapshot_pkg::SET_PACER_ON_TIME && !argOnOk)
                    && !(cmdCode == gated_count_snapshot_pkg::SET_PACER_OFF_TIME && !argOffOk);
    assign ackNext   = (isCmd && cmdCode == gated_count_snapshot_pkg::ACK_MODE_ON) ? 1'b1
                     : (isCmd && cmdCode == gated_count_snapshot_pkg::ACK_MODE_OFF) ? 1'b0
                     : ackMode_reg;

    assign flag2 = {1'b0, runOut, running_reg, timOvf_reg, ovf_reg[7],
                    pinLvl_reg[gated_count_snapshot_pkg::PIN_GATE],
                    pinLvl_reg[gated_count_snapshot_pkg::PIN_STOP],
                    pinLvl_reg[gated_count_snapshot_pkg::PIN_START]};
    assign flag3 = {5'h00, acq_reg == gated_count_snapshot_pkg::ACQ_EDGE_ARM
                           || acq_reg == gated_count_snapshot_pkg::ACQ_EDGE_RUN,
                    acq_reg == gated_count_snapshot_pkg::ACQ_CLK_ON
                           || acq_reg == gated_count_snapshot_pkg::ACQ_CLK_OFF,
                    acq_reg == gated_count_snapshot_pkg::ACQ_LEVEL};

    always_comb begin
        isQuery = 1'b1;
        case (cmdCode)
            gated_count_snapshot_pkg::QUERY_RECORD_POINTER: queryData = {27'h0, ptr_reg};
            gated_count_snapshot_pkg::QUERY_END_POINTER:    queryData = {27'h0, end_reg};
            gated_count_snapshot_pkg::QUERY_PACER_ON_TIME:  queryData = onTime_reg;
            gated_count_snapshot_pkg::QUERY_PACER_OFF_TIME: queryData = offTime_reg;
            gated_count_snapshot_pkg::READ_OVERFLOW_LOW:
                queryData = {37'h0, ovf_reg[3:0]};
            gated_count_snapshot_pkg::READ_OVERFLOW_MID:
                queryData = {38'h0, ovf_reg[6:4]};
            gated_count_snapshot_pkg::READ_INPUT_STATUS:    queryData = {33'h0, flag2};
            gated_count_snapshot_pkg::READ_ACQ_MODE:        queryData = {33'h0, flag3};
            gated_count_snapshot_pkg::READ_RECORD:          queryData = rdWord;
            default: begin
                isQuery   = 1'b0;
                queryData = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ackMode_reg <= 1'b0;
            replyValid  <= 1'b0;
            replyKind   <= gated_count_snapshot_pkg::REP_OK;
            replyData   <= '0;
        end else begin
            ackMode_reg <= ackNext;
            replyValid  <= isCmd && (isQuery || ackNext
                        || cmdCode == gated_count_snapshot_pkg::ACK_MODE_QUERY);
            replyData   <= isCmd ? queryData : replyData;
            if (isCmd) begin
                if (cmdCode == gated_count_snapshot_pkg::ACK_MODE_QUERY) begin
                    replyKind <= ackMode_reg ? gated_count_snapshot_pkg::REP_EN
                                             : gated_count_snapshot_pkg::REP_DS;
                end else if (isQuery) begin
                    replyKind <= gated_count_snapshot_pkg::REP_DATA;
                end else begin
                    replyKind <= accept ? gated_count_snapshot_pkg::REP_OK
                                        : gated_count_snapshot_pkg::REP_NG;
                end
            end
        end
    end

    // ==========================================================
    // Pointers and pacer settings
    // ==========================================================
    logic [PW-1:0] ptrStep;

    // The pointer holds at the top record rather than wrap
    assign ptrStep = (ptr_reg == gated_count_snapshot_pkg::REC_LAST) ? ptr_reg
                   : ptr_reg + 14'h0001;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ptr_reg     <= '0;
            end_reg     <= gated_count_snapshot_pkg::REC_LAST;
            onTime_reg  <= gated_count_snapshot_pkg::PACER_RST;
            offTime_reg <= '0;
        end else begin
            if (isCmd && (cmdCode == gated_count_snapshot_pkg::POINTER_CLEAR || memClr)) begin
                ptr_reg <= '0;
            end else if (isCmd && cmdCode == gated_count_snapshot_pkg::SET_RECORD_POINTER
                         && argAddrOk) begin
                ptr_reg <= cmdArg[PW-1:0];
            end else if (snap) begin
                ptr_reg <= ptrStep;
            end
            if (isCmd && cmdCode == gated_count_snapshot_pkg::SET_END_POINTER && argAddrOk) begin
                end_reg <= cmdArg[PW-1:0];
            end
            if (isCmd && cmdCode == gated_count_snapshot_pkg::SET_PACER_ON_TIME && argOnOk) begin
                onTime_reg <= cmdArg;
            end
            if (isCmd && cmdCode == gated_count_snapshot_pkg::SET_PACER_OFF_TIME && argOffOk) begin
                offTime_reg <= cmdArg;
            end
        end
    end
endmodule

//--- design/gated_count_snapshot_pkg.sv
// Constants and types for the gated count snapshot logger
//Contract
//- Flag byte 0: channels 0-3 overflow
//- Flag byte 1: channels 4-6 overflow
//- Flag byte 2: pins, ch7, timer, active, run
//- Ack mode: OK processed, NG refused
//- Ack query answers EN or DS
//- Ack off: silent for data-less commands
//- Level gate: count high, store at fall
//- Edge gate: open first fall, store later
//- Records 0-9999 hold eight channels, timer
//- Stop when pointer reaches end address
//- Pointer clear keeps stored records
//- Full clear zeroes pointer and records
//- Pointer settable 0-9999, readable
//- End address settable 0-9999, readable
//- Level start logs pointer to end; reset stopped
//- Edge start logs pointer to end address
//- Stop ends any acquisition at once
//- Pacer clock paces, gate still gates counting
//- Open gate is high; positive polarity default
//- On time 1 to 2^40 us, readable
//- Off time in us; zero gives 200 ns
package gated_count_snapshot_pkg;
    localparam int CH_N     = 8;
    localparam int CNT_W    = 32;
    localparam int TIM_W    = 40;
    localparam int ARG_W    = 41;
    localparam int ADDR_W   = 14;
    localparam int SEL_W    = 4;
    localparam int PIN_N    = 11;
    localparam int PIN_START = 8;
    localparam int PIN_STOP  = 9;
    localparam int PIN_GATE  = 10;
    localparam logic [ADDR_W-1:0] REC_LAST = 14'h270f;
    localparam logic [ARG_W-1:0]  PACER_MAX = 41'h100_0000_0000;
    localparam logic [ARG_W-1:0]  PACER_RST = 41'h000_0000_0001;
    localparam logic [SEL_W-1:0]  TIMER_SEL = 4'h8;
    localparam int CLK_NS     = 40;
    localparam int US_NS      = 1000;
    localparam int OFF_MIN_NS = 200;
    localparam logic [4:0] US_CYC = 5'(US_NS / CLK_NS);
    localparam logic [2:0] OFF_MIN_CYC = 3'((OFF_MIN_NS + CLK_NS - 1) / CLK_NS);
    localparam int F2_START = 0;
    localparam int F2_STOP  = 1;
    localparam int F2_GATE  = 2;
    localparam int F2_OVF7  = 3;
    localparam int F2_OVFT  = 4;
    localparam int F2_ACT   = 5;
    localparam int F2_RUN   = 6;
    localparam int F3_LEVEL = 0;
    localparam int F3_CLOCK = 1;
    localparam int F3_EDGE  = 2;

    typedef enum logic [4:0] {
        ACK_MODE_QUERY, ACK_MODE_ON, ACK_MODE_OFF, POINTER_CLEAR,
        POINTER_AND_MEMORY_CLEAR, SET_RECORD_POINTER, QUERY_RECORD_POINTER,
        SET_END_POINTER, QUERY_END_POINTER, LEVEL_GATE_LOG_BEGIN,
        EDGE_GATE_LOG_BEGIN, PACER_LOG_BEGIN, SET_PACER_ON_TIME,
        QUERY_PACER_ON_TIME, SET_PACER_OFF_TIME, QUERY_PACER_OFF_TIME,
        COUNT_BEGIN_CMD, COUNT_STOP_CMD, READ_OVERFLOW_LOW, READ_OVERFLOW_MID,
        READ_INPUT_STATUS, READ_ACQ_MODE, READ_RECORD
    } cmd_type;

    typedef enum logic [2:0] {REP_OK, REP_NG, REP_EN, REP_DS, REP_DATA} reply_type;

    typedef enum logic [2:0] {
        ACQ_IDLE, ACQ_LEVEL, ACQ_EDGE_ARM, ACQ_EDGE_RUN, ACQ_CLK_ON, ACQ_CLK_OFF
    } acq_type;
endpackage

//--- tb/gate_pulse_source.sv
// Gate source: idle high, one low pulse per request
`timescale 1ns/10ps
module gate_pulse_source #(parameter int LOW_CYC = 8) (
    input wire logic sys_clk, fire,
    output logic     gatePin
);
    int lowLeft = 0;
    // Released gate sits high, as an open input does
    assign gatePin = (lowLeft == 0);
    // Bench spaces the falls; period scaled down for simulation
    always @(posedge sys_clk) begin
        if (fire) lowLeft <= LOW_CYC;
        else if (lowLeft != 0) lowLeft <= lowLeft - 1;
    end
endmodule

//--- tb/gated_count_snapshot_monitor.sv
// Port checker for the gated count snapshot logger
`timescale 1ns/10ps
`define M(n) gated_count_snapshot_pkg::n
module gated_count_snapshot_monitor (
    // Clock, reset and levels
    input wire logic                       sys_clk,
    input wire logic                       rstn,
    input wire logic                       runOut,
    // Command and reply
    input wire logic                       cmdValid,
    input wire logic                       replyValid,
    input wire `M(cmd_type)                cmdCode,
    input wire `M(reply_type)              replyKind,
    input wire logic [`M(ARG_W)-1:0]       replyData
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    logic ackOn_reg;
    wire  isCmd = cmdValid && cmdCode inside {`M(POINTER_CLEAR),
        `M(SET_RECORD_POINTER), `M(SET_END_POINTER)};
    // Shadow of the acknowledge mode
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) ackOn_reg <= 1'b0;
        else if (cmdValid && cmdCode == `M(ACK_MODE_ON)) ackOn_reg <= 1'b1;
        else if (cmdValid && cmdCode == `M(ACK_MODE_OFF)) ackOn_reg <= 1'b0;
    end
    chk_reply_needs_cmd: assert property (replyValid |-> $past(cmdValid))
        else $error("reply without command");
    chk_ack_on_answers: assert property (isCmd && ackOn_reg |=> replyValid &&
        replyKind inside {`M(REP_OK), `M(REP_NG)})
        else $error("missing OK or NG");
    chk_ack_off_silent: assert property (isCmd && !ackOn_reg |=> !replyValid)
        else $error("reply while silent");
    chk_ack_query_kind: assert property (cmdValid && cmdCode ==
        `M(ACK_MODE_QUERY) |=> replyValid && replyKind ==
        (ackOn_reg ? `M(REP_EN) : `M(REP_DS)))
        else $error("ack query kind bad");
    chk_ptr_in_range: assert property (cmdValid && cmdCode ==
        `M(QUERY_RECORD_POINTER) |=> replyValid && replyData <= 41'h270f)
        else $error("pointer out of range");
    chk_end_in_range: assert property (cmdValid && cmdCode ==
        `M(QUERY_END_POINTER) |=> replyValid && replyData <= 41'h270f)
        else $error("end address out of range");
    chk_low_flag_bits: assert property (cmdValid && cmdCode ==
        `M(READ_OVERFLOW_LOW) |=> replyData[40:4] == 37'h0)
        else $error("flag byte 0 upper bits");
    chk_mid_flag_bits: assert property (cmdValid && cmdCode ==
        `M(READ_OVERFLOW_MID) |=> replyData[40:3] == 38'h0)
        else $error("flag byte 1 upper bits");
    chk_run_flag_bit: assert property (cmdValid && cmdCode ==
        `M(READ_INPUT_STATUS) |=> replyData[6] == $past(runOut))
        else $error("run bit differs");
    chk_stop_drops_run: assert property (cmdValid && cmdCode ==
        `M(COUNT_STOP_CMD) |=> !runOut)
        else $error("run stays after stop");
    cover property (cmdValid && cmdCode == `M(LEVEL_GATE_LOG_BEGIN));
    cover property (cmdValid && cmdCode == `M(EDGE_GATE_LOG_BEGIN));
    cover property (cmdValid && cmdCode == `M(PACER_LOG_BEGIN));
endmodule
bind gated_count_snapshot_logger gated_count_snapshot_monitor mon_u (.sys_clk, .rstn, .runOut,
    .cmdValid, .replyValid, .cmdCode, .replyKind, .replyData);

//--- tb/tb_top.sv
// Self-checking bench for the gated count snapshot logger
`timescale 1ns/10ps
`define K(n) gated_count_snapshot_pkg::n
`define CHK(a, e) begin checksDone++; if ((a) !== (e)) begin nErrors++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module tb_top;
    logic sys_clk = 1'b0, rstn = 1'b0, startPin = 1'b0, stopPin = 1'b0, gateNegative = 1'b0;
    logic cmdValid = 1'b0, fire = 1'b0, runOut, replyValid, gatePin, rv;
    logic [7:0] countPin = 8'h00;
    logic [40:0] cmdArg = 41'h0, replyData, rd;
    `K(cmd_type) cmdCode = `K(ACK_MODE_QUERY);
    `K(reply_type) replyKind, rk;
    int nErrors = 0, checksDone = 0;
    always #20 sys_clk = ~sys_clk;
    gated_count_snapshot_logger dut_u (.sys_clk, .rstn, .countPin, .startPin, .stopPin,
        .gatePin, .gateNegative, .runOut, .cmdValid, .cmdCode, .cmdArg, .replyValid,
        .replyKind, .replyData);
    gate_pulse_source #(.LOW_CYC(8)) gate_u (.sys_clk, .fire, .gatePin);
    // Reply pulse stands for the cycle after the command edge
    task cmd(input `K(cmd_type) c, input logic [40:0] a);
        cmdValid <= 1'b1; cmdCode <= c; cmdArg <= a;
        @(posedge sys_clk); cmdValid <= 1'b0;
        #1 rv = replyValid; rk = replyKind; rd = replyData;
        @(posedge sys_clk);
    endtask
    task q(input `K(cmd_type) c, input logic [40:0] a, e);
        cmd(c, a); `CHK({rv, rd}, {1'b1, e})
    endtask
    task pulses(input int n);
        repeat (n) begin
            countPin <= 8'h01; repeat (3) @(posedge sys_clk);
            countPin <= 8'h00; repeat (3) @(posedge sys_clk);
        end
    endtask
    task fall();
        repeat (6) @(posedge sys_clk); fire <= 1'b1;
        @(posedge sys_clk); fire <= 1'b0; repeat (20) @(posedge sys_clk);
    endtask
    task t_reset();
        q(`K(QUERY_RECORD_POINTER), 41'h0, 41'h0);
        q(`K(QUERY_END_POINTER), 41'h0, 41'h270f);
        q(`K(READ_ACQ_MODE), 41'h0, 41'h0);
        q(`K(READ_OVERFLOW_LOW), 41'h0, 41'h0);
        q(`K(READ_OVERFLOW_MID), 41'h0, 41'h0);
        cmd(`K(READ_INPUT_STATUS), 41'h0); `CHK(rd[2], 1'b1)
        $display("test reset done");
    endtask
    task t_ranges();
        cmd(`K(SET_RECORD_POINTER), 41'h270f); `CHK(rv, 1'b0)
        cmd(`K(SET_RECORD_POINTER), 41'h2710);
        q(`K(QUERY_RECORD_POINTER), 41'h0, 41'h270f);
        cmd(`K(SET_END_POINTER), 41'h270e);
        q(`K(QUERY_END_POINTER), 41'h0, 41'h270e);
        cmd(`K(SET_PACER_ON_TIME), 41'h100_0000_0000);
        q(`K(QUERY_PACER_ON_TIME), 41'h0, 41'h100_0000_0000);
        $display("test ranges done");
    endtask
    task t_ack();
        cmd(`K(ACK_MODE_ON), 41'h0); `CHK(rk, `K(REP_OK))
        cmd(`K(ACK_MODE_QUERY), 41'h0); `CHK(rk, `K(REP_EN))
        cmd(`K(POINTER_CLEAR), 41'h0); `CHK(rk, `K(REP_OK))
        cmd(`K(SET_END_POINTER), 41'h2710); `CHK(rk, `K(REP_NG))
        cmd(`K(ACK_MODE_OFF), 41'h0);
        cmd(`K(ACK_MODE_QUERY), 41'h0); `CHK(rk, `K(REP_DS))
        $display("test ack done");
    endtask
    task t_level();
        cmd(`K(SET_RECORD_POINTER), 41'h5);
        cmd(`K(SET_END_POINTER), 41'h6);
        cmd(`K(LEVEL_GATE_LOG_BEGIN), 41'h0);
        q(`K(READ_ACQ_MODE), 41'h0, 41'h1);
        pulses(4); fall();
        q(`K(QUERY_RECORD_POINTER), 41'h0, 41'h6);
        pulses(2); fall();
        q(`K(QUERY_RECORD_POINTER), 41'h0, 41'h7);
        q(`K(READ_ACQ_MODE), 41'h0, 41'h0);
        pulses(1); fall();
        q(`K(QUERY_RECORD_POINTER), 41'h0, 41'h7);
        q(`K(READ_RECORD), 41'h50, 41'h4);
        q(`K(READ_RECORD), 41'h60, 41'h2);
        $display("test level done");
    endtask
    task t_clear();
        cmd(`K(POINTER_CLEAR), 41'h0);
        q(`K(QUERY_RECORD_POINTER), 41'h0, 41'h0);
        q(`K(READ_RECORD), 41'h50, 41'h4);
        cmd(`K(POINTER_AND_MEMORY_CLEAR), 41'h0);
        q(`K(READ_RECORD), 41'h50, 41'h0);
        $display("test clear done");
    endtask
    task t_edge();
        cmd(`K(SET_END_POINTER), 41'h1);
        cmd(`K(EDGE_GATE_LOG_BEGIN), 41'h0);
        q(`K(READ_ACQ_MODE), 41'h0, 41'h4);
        fall();
        q(`K(QUERY_RECORD_POINTER), 41'h0, 41'h0);
        pulses(3); fall();
        q(`K(READ_RECORD), 41'h0, 41'h3);
        cmd(`K(COUNT_STOP_CMD), 41'h0);
        q(`K(READ_ACQ_MODE), 41'h0, 41'h0);
        fall();
        q(`K(QUERY_RECORD_POINTER), 41'h0, 41'h1);
        $display("test edge done");
    endtask
    task t_pacer();
        cmd(`K(POINTER_CLEAR), 41'h0);
        cmd(`K(SET_PACER_ON_TIME), 41'h2);
        cmd(`K(SET_PACER_OFF_TIME), 41'h0);
        cmd(`K(PACER_LOG_BEGIN), 41'h0);
        q(`K(READ_ACQ_MODE), 41'h0, 41'h2);
        repeat (300) @(posedge sys_clk);
        q(`K(QUERY_RECORD_POINTER), 41'h0, 41'h2);
        $display("test pacer done");
    endtask
    task endSim();
        $display("comparisons %0d mismatches %0d", checksDone, nErrors);
        if (nErrors == 0 && checksDone > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        t_reset(); t_ranges(); t_ack(); t_level(); t_clear(); t_edge(); t_pacer();
        endSim();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        nErrors++;
        endSim();
    end
endmodule
